// ### hw/sfsi_pkg.sv
// Shared types and constants for the supply and fault status indicators.
// Assumes a 10 MHz system clock and a classic Wishbone register port.
//
// Summary of operation
// - Active of two: orange on marginal, hours, fan
// - Red when module 12 V out of range
// - Red: unplugged of two, or idle fan fail
// - Orange drops at once when condition clears
// - Red held about thirty seconds after clearing
// - Faulted active swaps to good backup automatically
// - Software picks the preferred active module
// - Fault lamp blinks red: fan stopped, overheat
// - Blinking lasts until fan turns, temperature normal
// - Solid red: fan speed or voltage bad
// - Solid amber: PLL unlock, phase error, hours
// - Fault lamp off when nothing is wrong
// - Fault-free backup of two shows dim green
// - Fault-free active module shows bright green
// - Backup marginal or over hours: dim orange
package sfsi_pkg;

   // Clock rate and derived timing
   localparam int unsigned SFSI_CLK_HZ = 10_000_000;
   localparam int unsigned SFSI_HOLD_TIME_S = 30;  // Red hold after clearing
   localparam int unsigned SFSI_HOLD_CYCLES = SFSI_HOLD_TIME_S * SFSI_CLK_HZ;
   localparam int unsigned SFSI_BLINK_HALF_MS = 500;  // Blink half period
   localparam int unsigned SFSI_BLINK_HALF_CYCLES = (SFSI_CLK_HZ / 1000) * SFSI_BLINK_HALF_MS;

   // Register map, byte addresses
   localparam int SFSI_ADDR_W = 8;
   localparam logic [7:0] SFSI_CTRL_OFF = 8'h00;
   localparam logic [7:0] SFSI_STATUS_OFF = 8'h04;
   localparam logic [7:0] SFSI_FLAGS_OFF = 8'h08;

   // Control field
   localparam int SFSI_CTRL_PREF_BIT = 0;  // 0 prefers supply one
   localparam logic SFSI_CTRL_PREF_RST = 1'b0;

   // Status fields
   localparam int SFSI_ST_ONE_LSB = 0;
   localparam int SFSI_ST_TWO_LSB = 3;
   localparam int SFSI_ST_LAMP_LSB = 6;
   localparam int SFSI_ST_ACTIVE_BIT = 8;
   localparam int SFSI_ST_TWO_FIT_BIT = 9;

   // Indicator colours of one supply module
   typedef enum logic [2:0] {
      SFSI_OFF,
      SFSI_DIM_GREEN,
      SFSI_BRIGHT_GREEN,
      SFSI_DIM_ORANGE,
      SFSI_BRIGHT_ORANGE,
      SFSI_RED
   } sfsi_colour_t;

   // Fault lamp states
   typedef enum logic [1:0] {
      SFSI_LAMP_OFF,
      SFSI_LAMP_AMBER,
      SFSI_LAMP_BLINK,
      SFSI_LAMP_SOLID
   } sfsi_lamp_t;

   // Condition flags of one supply module
   typedef struct packed {
      logic installed;
      logic ac_ok;
      logic marginal;
      logic v12_bad;
      logic fan_fail;
      logic hours_over;
   } sfsi_supply_flags_t;

   // Instrument-wide condition flags
   typedef struct packed {
      logic main_fan_stopped;
      logic over_temp;
      logic fan_speed_bad;
      logic int_volt_bad;
      logic main_pll_unlock;
      logic sdi_pll_unlock;
      logic phase_err;
   } sfsi_instr_flags_t;

   localparam int SFSI_FLAGS_W = 2 * $bits(sfsi_supply_flags_t) + $bits(sfsi_instr_flags_t);

endpackage : sfsi_pkg

// ### hw/sfsi_blinker.sv
// Free-running blink level for the fault lamp.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfsi_blinker
   import sfsi_pkg::*;
#(
   parameter int unsigned HALF_CYCLES = SFSI_BLINK_HALF_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   output logic blink_o
);

   logic [31:0] cnt;  // Cycles left in this half period
   logic [31:0] next_cnt;
   logic next_blink;

   // Count down, toggle at each half period end
   always_comb begin
      next_cnt = cnt - 32'h1;
      next_blink = blink_o;
      if (cnt == 32'h0) begin
         next_cnt = 32'(HALF_CYCLES - 1);
         next_blink = ~blink_o;
      end
   end

   // Register state
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt <= 32'h0;
         blink_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         blink_o <= next_blink;
      end
   end

endmodule : sfsi_blinker
`default_nettype wire

// ### hw/sfsi_supply_eval.sv
// Colour decision and red hold timer for one supply module.
// Assumes flags already synchronised and active role given by the top.
`timescale 1ns/1ps
`default_nettype none
module sfsi_supply_eval
   import sfsi_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = SFSI_HOLD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire sfsi_supply_flags_t flags_i,
   input wire logic two_fitted_i,
   input wire logic active_i,
   output sfsi_colour_t colour_o,
   output logic faulted_o
);

   logic [31:0] hold;  // Red hold countdown
   logic [31:0] next_hold;
   sfsi_colour_t next_colour;
   logic next_faulted;
   logic red_cond;  // Live red condition
   logic orange_cond;  // Live warning condition
   logic red_shown;

   // Conditions and next colour
   always_comb begin
      red_cond = flags_i.installed & (flags_i.v12_bad
         | (two_fitted_i & ~flags_i.ac_ok)
         | (~active_i & flags_i.fan_fail));
      orange_cond = flags_i.installed & (flags_i.marginal | flags_i.hours_over
         | (active_i & flags_i.fan_fail));
      next_hold = hold;
      if (!flags_i.installed) begin
         next_hold = 32'h0;  // Removed module forgets its fault
      end else if (red_cond) begin
         next_hold = 32'(HOLD_CYCLES);
      end else if (hold != 32'h0) begin
         next_hold = hold - 32'h1;
      end
      red_shown = flags_i.installed & (red_cond | (hold != 32'h0));
      next_faulted = red_shown;
      if (!flags_i.installed) begin
         next_colour = SFSI_OFF;
      end else if (red_shown) begin
         next_colour = SFSI_RED;
      end else if (orange_cond) begin
         // Orange follows the live condition, no hold
         next_colour = active_i ? SFSI_BRIGHT_ORANGE : SFSI_DIM_ORANGE;
      end else begin
         next_colour = active_i ? SFSI_BRIGHT_GREEN : SFSI_DIM_GREEN;
      end
   end

   // Register state
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hold <= 32'h0;
         colour_o <= SFSI_OFF;
         faulted_o <= 1'b0;
      end else begin
         hold <= next_hold;
         colour_o <= next_colour;
         faulted_o <= next_faulted;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Fault present then gone while installed
   sequence s_fault_clears;
      red_cond ##1 (!red_cond && flags_i.installed);
   endsequence

   a_red_hold_start: assert property (s_fault_clears |=> colour_o == SFSI_RED)
      else $error("red not held after fault cleared");
   a_orange_drop: assert property (flags_i.installed && !red_cond && hold == 32'h0
      && !orange_cond |=> colour_o inside {SFSI_DIM_GREEN, SFSI_BRIGHT_GREEN})
      else $error("orange kept after condition cleared");
   a_active_green: assert property (flags_i.installed && active_i && !red_cond
      && hold == 32'h0 && !orange_cond |=> colour_o == SFSI_BRIGHT_GREEN)
      else $error("fault-free active not bright green");
   a_backup_dim: assert property (flags_i.installed && !active_i && two_fitted_i
      && !red_cond && hold == 32'h0 && (flags_i.marginal || flags_i.hours_over)
      |=> colour_o == SFSI_DIM_ORANGE)
      else $error("backup warning not dim orange");
   a_active_warn: assert property (flags_i.installed && active_i && !red_cond
      && hold == 32'h0 && flags_i.fan_fail |=> colour_o == SFSI_BRIGHT_ORANGE)
      else $error("active fan failure not bright orange");

endmodule : sfsi_supply_eval
`default_nettype wire

// ### hw/sfsi_top.sv
// Top of the supply and fault status indicators with Wishbone slave.
// Condition flags arrive as asynchronous pins; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sfsi_top
   import sfsi_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = SFSI_HOLD_CYCLES,
   parameter int unsigned BLINK_HALF_CYCLES = SFSI_BLINK_HALF_CYCLES
) (
   input wire logic CLK_I,  // System clock
   input wire logic RST_N_I,  // Synchronous reset, active low
   input wire logic WB_CYC_I,  // Wishbone cycle
   input wire logic WB_STB_I,  // Wishbone strobe
   input wire logic WB_WE_I,  // Wishbone write enable
   input wire logic [SFSI_ADDR_W-1:0] WB_ADR_I,  // Byte address
   input wire logic [3:0] WB_SEL_I,  // Byte lane selects
   input wire logic [31:0] WB_DAT_I,  // Write data
   output logic [31:0] WB_DAT_O,  // Read data
   output logic WB_ACK_O,  // Acknowledge
   input wire sfsi_supply_flags_t SUPPLY_ONE_FLAGS_I,  // Module one conditions
   input wire sfsi_supply_flags_t SUPPLY_TWO_FLAGS_I,  // Module two conditions
   input wire sfsi_instr_flags_t INSTR_FLAGS_I,  // Instrument conditions
   output sfsi_colour_t SUPPLY_ONE_INDICATOR_O,  // Module one colour
   output sfsi_colour_t SUPPLY_TWO_INDICATOR_O,  // Module two colour
   output logic FAULT_RED_O,  // Fault lamp red drive
   output logic FAULT_AMBER_O,  // Fault lamp amber drive
   output logic ACTIVE_SUPPLY_O  // 0 module one active, 1 module two
);

   // Flag synchroniser stages
   logic [SFSI_FLAGS_W-1:0] sync_a;  // First stage, read only by second
   logic [SFSI_FLAGS_W-1:0] sync_b;
   logic [SFSI_FLAGS_W-1:0] sync_c;
   logic [SFSI_FLAGS_W-1:0] stable;  // Agreed flag values
   logic [SFSI_FLAGS_W-1:0] next_stable;
   logic [SFSI_FLAGS_W-1:0] raw_flags;

   // Unpacked views of the agreed flags
   sfsi_supply_flags_t st_one;
   sfsi_supply_flags_t st_two;
   sfsi_instr_flags_t st_ins;
   logic two_fitted;  // Both modules installed

   // Role selection
   logic pref;  // Preferred active module
   logic next_pref;
   logic active;  // Present active module
   logic next_active;
   logic faulted_one;
   logic faulted_two;
   logic good_one;
   logic good_two;
   logic good_pref;
   logic good_act;
   logic good_oth;

   // Fault lamp
   sfsi_lamp_t lamp;
   sfsi_lamp_t next_lamp;
   logic solid_cond;
   logic blink_cond;
   logic amber_cond;
   logic blink_lvl;
   logic next_red;
   logic next_amber;

   // Bus slave
   logic next_ack;
   logic [31:0] next_dat;
   logic [31:0] rd_word;
   logic bus_req;

   // All condition pins as one vector
   assign raw_flags = {INSTR_FLAGS_I, SUPPLY_TWO_FLAGS_I, SUPPLY_ONE_FLAGS_I};

   // Take a flag bit once the second and third stages agree
   always_comb begin
      next_stable = (sync_b & ~(sync_b ^ sync_c)) | (stable & (sync_b ^ sync_c));
   end

   // Synchroniser registers
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
         stable <= '0;
      end else begin
         sync_a <= raw_flags;
         sync_b <= sync_a;
         sync_c <= sync_b;
         stable <= next_stable;
      end
   end

   // Split agreed flags back into groups
   always_comb begin
      {st_ins, st_two, st_one} = stable;
      two_fitted = st_one.installed & st_two.installed;
   end

   // Module one colour
   sfsi_supply_eval #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_eval_one (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .flags_i(st_one),
      .two_fitted_i(two_fitted),
      .active_i(~active),
      .colour_o(SUPPLY_ONE_INDICATOR_O),
      .faulted_o(faulted_one)
   );

   // Module two colour
   sfsi_supply_eval #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_eval_two (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .flags_i(st_two),
      .two_fitted_i(two_fitted),
      .active_i(active),
      .colour_o(SUPPLY_TWO_INDICATOR_O),
      .faulted_o(faulted_two)
   );

   // Blink level for the fault lamp
   sfsi_blinker #(
      .HALF_CYCLES(BLINK_HALF_CYCLES)
   ) u_blink (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .blink_o(blink_lvl)
   );

   // Choose the active module
   always_comb begin
      good_one = st_one.installed & ~faulted_one;
      good_two = st_two.installed & ~faulted_two;
      good_pref = pref ? good_two : good_one;
      good_act = active ? good_two : good_one;
      good_oth = active ? good_one : good_two;
      next_active = active;
      if (good_pref) begin
         next_active = pref;
      end else if (!good_act && good_oth) begin
         next_active = ~active;
      end
   end

   // Role register
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         active <= SFSI_CTRL_PREF_RST;
      end else begin
         active <= next_active;
      end
   end

   // Role visible on a pin
   assign ACTIVE_SUPPLY_O = active;

   // Fault lamp decision, most severe first
   always_comb begin
      solid_cond = st_ins.fan_speed_bad | st_ins.int_volt_bad;
      blink_cond = st_ins.main_fan_stopped | st_ins.over_temp;
      amber_cond = st_ins.main_pll_unlock | st_ins.sdi_pll_unlock | st_ins.phase_err
         | (st_one.installed & st_one.hours_over)
         | (st_two.installed & st_two.hours_over);
      if (solid_cond) begin
         next_lamp = SFSI_LAMP_SOLID;
      end else if (blink_cond) begin
         next_lamp = SFSI_LAMP_BLINK;
      end else if (amber_cond) begin
         next_lamp = SFSI_LAMP_AMBER;
      end else begin
         next_lamp = SFSI_LAMP_OFF;
      end
      next_red = (next_lamp == SFSI_LAMP_SOLID)
         | ((next_lamp == SFSI_LAMP_BLINK) & blink_lvl);
      next_amber = (next_lamp == SFSI_LAMP_AMBER);
   end

   // Lamp registers
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         lamp <= SFSI_LAMP_OFF;
         FAULT_RED_O <= 1'b0;
         FAULT_AMBER_O <= 1'b0;
      end else begin
         lamp <= next_lamp;
         FAULT_RED_O <= next_red;
         FAULT_AMBER_O <= next_amber;
      end
   end

   // Read word decode
   always_comb begin
      rd_word = 32'h0;
      unique case (WB_ADR_I)
         SFSI_CTRL_OFF: begin
            rd_word[SFSI_CTRL_PREF_BIT] = pref;
         end
         SFSI_STATUS_OFF: begin
            rd_word[SFSI_ST_ONE_LSB +: 3] = SUPPLY_ONE_INDICATOR_O;
            rd_word[SFSI_ST_TWO_LSB +: 3] = SUPPLY_TWO_INDICATOR_O;
            rd_word[SFSI_ST_LAMP_LSB +: 2] = lamp;
            rd_word[SFSI_ST_ACTIVE_BIT] = active;
            rd_word[SFSI_ST_TWO_FIT_BIT] = two_fitted;
         end
         SFSI_FLAGS_OFF: begin
            rd_word[SFSI_FLAGS_W-1:0] = stable;
         end
         default: begin
            rd_word = 32'h0;  // Unmapped reads as zero
         end
      endcase
   end

   // Bus answer: ack one cycle after request, write on the ack edge
   always_comb begin
      bus_req = WB_CYC_I & WB_STB_I;
      next_ack = bus_req & ~WB_ACK_O;
      next_dat = WB_DAT_O;
      if (next_ack && !WB_WE_I) begin
         next_dat = rd_word;
      end
      next_pref = pref;
      if (bus_req && WB_ACK_O && WB_WE_I && WB_SEL_I[0]
         && WB_ADR_I == SFSI_CTRL_OFF) begin
         next_pref = WB_DAT_I[SFSI_CTRL_PREF_BIT];
      end
   end

   // Bus registers
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
         pref <= SFSI_CTRL_PREF_RST;
      end else begin
         WB_ACK_O <= next_ack;
         WB_DAT_O <= next_dat;
         pref <= next_pref;
      end
   end

   // Checks run on the system clock, off in reset
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   // Empty position stays dark
   a_absent_off: assert property (!st_one.installed
      |=> SUPPLY_ONE_INDICATOR_O == SFSI_OFF)
      else $error("absent module one not off");
   // Empty second position stays dark
   a_absent_two: assert property (!st_two.installed
      |=> SUPPLY_TWO_INDICATOR_O == SFSI_OFF)
      else $error("absent module two not off");
   // Rail out of range turns the module red
   a_rail_red: assert property (st_two.installed && st_two.v12_bad
      |=> SUPPLY_TWO_INDICATOR_O == SFSI_RED)
      else $error("module two rail fault not red");
   // Same for module one
   a_rail_one: assert property (st_one.installed && st_one.v12_bad
      |=> SUPPLY_ONE_INDICATOR_O == SFSI_RED)
      else $error("module one rail fault not red");
   // Fitted pair without mains shows red
   a_unplugged_red: assert property (two_fitted && !st_one.ac_ok
      |=> SUPPLY_ONE_INDICATOR_O == SFSI_RED)
      else $error("unplugged module one not red");
   // Same for module two
   a_unplugged_two: assert property (two_fitted && !st_two.ac_ok
      |=> SUPPLY_TWO_INDICATOR_O == SFSI_RED)
      else $error("unplugged module two not red");
   // Backup with a dead fan shows red
   a_idle_fan_two: assert property (st_two.installed && !active && st_two.fan_fail
      |=> SUPPLY_TWO_INDICATOR_O == SFSI_RED)
      else $error("idle module two fan failure not red");
   // Same for module one while module two leads
   a_idle_fan_one: assert property (st_one.installed && active && st_one.fan_fail
      |=> SUPPLY_ONE_INDICATOR_O == SFSI_RED)
      else $error("idle module one fan failure not red");

   // Faulted active hands over to a good backup
   a_swap_good: assert property (!good_act && good_oth
      |=> active != $past(active))
      else $error("faulted active not swapped");
   // A good active module is not dropped for nothing
   a_role_keep: assert property (good_act && !good_pref
      |=> active == $past(active))
      else $error("good active module dropped");
   // Preferred module wins whenever it is good
   a_pref_taken: assert property (good_pref |=> active == $past(pref))
      else $error("preferred module not active");
   // A lone good module two takes the load
   a_lone_active: assert property (st_two.installed && !st_one.installed
      && !faulted_two |=> active)
      else $error("lone module two not active");

   // Lamp checks, most severe first
   a_solid_red: assert property (solid_cond |=> lamp == SFSI_LAMP_SOLID && FAULT_RED_O)
      else $error("solid red not shown");
   // Solid red never shows amber
   a_solid_no_amber: assert property (solid_cond |=> !FAULT_AMBER_O)
      else $error("amber shown with solid red");
   // Blinking red follows the blink level
   a_blink_red: assert property (blink_cond && !solid_cond
      |=> lamp == SFSI_LAMP_BLINK && !FAULT_AMBER_O && FAULT_RED_O == $past(blink_lvl))
      else $error("blinking red wrong");
   // Amber alone
   a_amber_lamp: assert property (amber_cond && !blink_cond && !solid_cond
      |=> FAULT_AMBER_O && !FAULT_RED_O)
      else $error("amber lamp not shown");
   // Worn module lights amber
   a_hours_amber: assert property (st_two.installed && st_two.hours_over
      && !blink_cond && !solid_cond |=> FAULT_AMBER_O)
      else $error("hours limit not amber");
   // Nothing wrong, lamp dark
   a_lamp_off: assert property (!amber_cond && !blink_cond && !solid_cond
      |=> !FAULT_AMBER_O && !FAULT_RED_O)
      else $error("fault lamp not off");

   // Bus: single-cycle ack
   a_bus_ack: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack not a single cycle");
   // Read data taken from the addressed word
   a_read_data: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I
      |=> WB_DAT_O == $past(rd_word))
      else $error("read data not the addressed word");
   // Control write lands on the ack edge
   a_pref_write: assert property (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I
      && WB_SEL_I[0] && WB_ADR_I == SFSI_CTRL_OFF
      |=> pref == $past(WB_DAT_I[SFSI_CTRL_PREF_BIT]))
      else $error("control write not taken");
   // No write, no change of preference
   a_pref_kept: assert property (!(WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I)
      |=> pref == $past(pref))
      else $error("preference changed without a write");

endmodule : sfsi_top
`default_nettype wire

// ### tb/sfsi_testbench.sv
// Self-checking bench for the supply and fault status indicators.
// Assumes the top module alone, a 10 MHz clock and short hold and blink counts.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sfsi_pkg::*;
;
   localparam int unsigned HOLD = 50;  // Shortened red hold
   localparam int unsigned HALF = 4;  // Shortened blink half period
   localparam sfsi_supply_flags_t NONE = 6'h00;  // Position empty
   localparam sfsi_supply_flags_t GOOD = 6'h30;  // Installed with AC
   localparam sfsi_instr_flags_t CALM = 7'h00;  // No instrument fault

   logic clk = 1'b0;  // System clock
   logic rst_n = 1'b0;  // Reset, active low
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;  // Bus request
   logic [7:0] adr = 8'h00;  // Bus address
   logic [3:0] sel = 4'h0;  // Byte lanes
   logic [31:0] wdat = 32'h0;  // Write data
   sfsi_supply_flags_t s1 = NONE, s2 = NONE;  // Module conditions
   sfsi_instr_flags_t fi = CALM;  // Instrument conditions
   wire logic [31:0] rdat;  // Read data
   wire logic ack, red, amber, act;  // Bus answer and lamp
   sfsi_colour_t ind1, ind2;  // Module colours
   logic [31:0] rd;  // Last value read
   int fail_count = 0;  // Mismatches
   int checked = 0;  // Comparisons

   sfsi_top #(.HOLD_CYCLES(HOLD), .BLINK_HALF_CYCLES(HALF)) u_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .SUPPLY_ONE_FLAGS_I(s1), .SUPPLY_TWO_FLAGS_I(s2), .INSTR_FLAGS_I(fi),
      .SUPPLY_ONE_INDICATOR_O(ind1), .SUPPLY_TWO_INDICATOR_O(ind2),
      .FAULT_RED_O(red), .FAULT_AMBER_O(amber), .ACTIVE_SUPPLY_O(act));

   // Half period of 50 ns
   always #50 clk = ~clk;

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Word compare
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   // Colour compare
   task automatic chk_col(input sfsi_colour_t got, input sfsi_colour_t exp);
      chk_word({29'h0, got}, {29'h0, exp});
   endtask : chk_col

   // Single bit compare
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_bit

   // Waits for ack, bounded
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         fail_count++;
         tally_and_finish();
      end
   endtask : wait_ack

   // Classic single write cycle
   task automatic wb_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= 1'b1; adr <= a; wdat <= d; sel <= s;
      wait_ack();
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb_write

   // Classic single read cycle
   task automatic wb_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= 1'b0; adr <= a; sel <= 4'hf;
      wait_ack();
      d = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb_read

   // Drives conditions and lets them pass the synchronisers
   task automatic apply(input sfsi_supply_flags_t a, input sfsi_supply_flags_t b,
                        input sfsi_instr_flags_t c, input int cycles);
      @(posedge clk);
      s1 <= a; s2 <= b; fi <= c;
      repeat (cycles) @(posedge clk);
   endtask : apply

   // Both lamp drives
   task automatic chk_lamp(input logic r, input logic a);
      chk_bit(red, r);
      chk_bit(amber, a);
   endtask : chk_lamp

   // Watches red over three half periods; returns whether it toggled or stayed up
   task automatic watch_red(output logic hi, output logic lo);
      hi = 1'b0;
      lo = 1'b0;
      repeat (3 * HALF) begin
         @(posedge clk);
         if (red === 1'b1) hi = 1'b1;
         if (red === 1'b0) lo = 1'b1;
      end
   endtask : watch_red

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      logic hi, lo;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk_col(ind1, SFSI_OFF);
      chk_bit(act, 1'b0);
      wb_read(SFSI_CTRL_OFF, rd);
      chk_word(rd, 32'h0);
      wb_read(8'h0c, rd);
      chk_word(rd, 32'h0);
      // Single module: bright green, empty position off
      apply(GOOD, NONE, CALM, 8);
      chk_col(ind1, SFSI_BRIGHT_GREEN);
      chk_col(ind2, SFSI_OFF);
      chk_lamp(1'b0, 1'b0);
      // Two good modules
      apply(GOOD, GOOD, CALM, 8);
      chk_col(ind1, SFSI_BRIGHT_GREEN);
      chk_col(ind2, SFSI_DIM_GREEN);
      wb_read(SFSI_STATUS_OFF, rd);
      chk_word(rd, 32'h20a);
      // Backup warnings, then immediate drop
      apply(GOOD, GOOD | 6'h08, CALM, 8);
      chk_col(ind2, SFSI_DIM_ORANGE);
      apply(GOOD, GOOD | 6'h01, CALM, 8);
      chk_col(ind2, SFSI_DIM_ORANGE);
      apply(GOOD, GOOD, CALM, 8);
      chk_col(ind2, SFSI_DIM_GREEN);
      // Active warnings
      apply(GOOD | 6'h08, GOOD, CALM, 8);
      chk_col(ind1, SFSI_BRIGHT_ORANGE);
      apply(GOOD, GOOD, CALM, 8);
      chk_col(ind1, SFSI_BRIGHT_GREEN);
      apply(GOOD | 6'h01, GOOD, CALM, 8);
      chk_col(ind1, SFSI_BRIGHT_ORANGE);
      chk_lamp(1'b0, 1'b1);
      apply(GOOD | 6'h02, GOOD, CALM, 8);
      chk_col(ind1, SFSI_BRIGHT_ORANGE);
      // Idle fan failure with a marginal voltage: red wins, then held
      apply(GOOD, GOOD | 6'h0a, CALM, 8);
      chk_col(ind2, SFSI_RED);
      wb_read(SFSI_FLAGS_OFF, rd);
      chk_word(rd, 32'h0000_0eb0);
      apply(GOOD, GOOD, CALM, 30);
      chk_col(ind2, SFSI_RED);
      repeat (HOLD) @(posedge clk);
      chk_col(ind2, SFSI_DIM_GREEN);
      // Backup installed without AC
      apply(GOOD, 6'h20, CALM, 8);
      chk_col(ind2, SFSI_RED);
      apply(GOOD, GOOD, CALM, HOLD + 30);
      // Preferred module chosen by control; unselected lane ignored
      wb_write(SFSI_CTRL_OFF, 32'h1, 4'h0);
      wb_read(SFSI_CTRL_OFF, rd);
      chk_word(rd, 32'h0);
      wb_write(SFSI_CTRL_OFF, 32'h1, 4'h1);
      repeat (8) @(posedge clk);
      chk_bit(act, 1'b1);
      chk_col(ind2, SFSI_BRIGHT_GREEN);
      chk_col(ind1, SFSI_DIM_GREEN);
      wb_write(SFSI_CTRL_OFF, 32'h0, 4'h1);
      repeat (8) @(posedge clk);
      chk_bit(act, 1'b0);
      // Active supply out of range: red and switch to the good one
      apply(GOOD | 6'h04, GOOD, CALM, 8);
      chk_col(ind1, SFSI_RED);
      chk_bit(act, 1'b1);
      chk_col(ind2, SFSI_BRIGHT_GREEN);
      apply(GOOD, GOOD, CALM, HOLD + 30);
      chk_bit(act, 1'b0);
      chk_col(ind1, SFSI_BRIGHT_GREEN);
      // Amber causes: phase error, both lock losses
      for (int i = 0; i < 3; i++) begin
         apply(GOOD, GOOD, sfsi_instr_flags_t'(7'h01 << i), 8);
         chk_lamp(1'b0, 1'b1);
      end
      // Blinking causes, each over a phase error amber
      for (int i = 5; i < 7; i++) begin
         apply(GOOD, GOOD, sfsi_instr_flags_t'((7'h01 << i) | 7'h01), 8);
         watch_red(hi, lo);
         chk_bit(hi & lo, 1'b1);
         chk_bit(amber, 1'b0);
      end
      apply(GOOD, GOOD, CALM, 8);
      chk_lamp(1'b0, 1'b0);
      // Solid red causes, over blinking and amber
      for (int i = 3; i < 5; i++) begin
         apply(GOOD, GOOD, sfsi_instr_flags_t'((7'h01 << i) | 7'h61), 8);
         watch_red(hi, lo);
         chk_bit(lo, 1'b0);
         chk_lamp(1'b1, 1'b0);
         wb_read(SFSI_STATUS_OFF, rd);
         chk_word(rd, 32'h0000_02ca);
      end
      apply(GOOD, GOOD, CALM, 8);
      chk_lamp(1'b0, 1'b0);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
